// ===== design/mmd_pkg.sv
package mmd_pkg;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    localparam logic [15:0] VEC_BASE       = 16'h0003;
    localparam int          VEC_SHIFT      = 3;
    localparam int          NUM_IRQ        = 4;
    localparam int          PROG_MAX_BYTES = 4096;
    localparam logic [7:0]  SFR_BASE       = 8'h80;
    localparam logic [7:0]  BIT_AREA_BASE  = 8'h20;
    localparam int          PHASES         = 4;
    localparam logic [1:0]  PHASE_LAST     = 2'h3;

    // data access kind as issued by the core
    typedef enum logic [1:0] {
        MMD_AM_DIRECT   = 2'h0,
        MMD_AM_INDIRECT = 2'h1,
        MMD_AM_REGISTER = 2'h3,
        MMD_AM_BIT      = 2'h2
    } mmd_mode_e;

    // machine cycle phases, gray sequence
    typedef enum logic [1:0] {
        MMD_PH0 = 2'h0,
        MMD_PH1 = 2'h1,
        MMD_PH2 = 2'h3,
        MMD_PH3 = 2'h2
    } mmd_phase_e;
endpackage : mmd_pkg

// ===== design/mmd_dec_if.sv
`timescale 1ns/1ns
`default_nettype none
// carries a decode request and its outcome between top and decoder
interface mmd_dec_if;
    logic [7:0] addr;
    logic [1:0] mode;
    logic [2:0] reg_idx;
    logic [1:0] bank;
    logic [7:0] ind_ptr;
    logic [7:0] ram_addr;
    logic [2:0] bit_sel;
    logic       is_ram;
    logic       is_sfr;
    logic       illegal;
    modport req (output addr, mode, reg_idx, bank, ind_ptr, input ram_addr, bit_sel, is_ram, is_sfr, illegal);
    modport dec (input addr, mode, reg_idx, bank, ind_ptr, output ram_addr, bit_sel, is_ram, is_sfr, illegal);
endinterface : mmd_dec_if
`default_nettype wire

// ===== design/mmd_addr_dec.sv
`timescale 1ns/1ns
`default_nettype none
module mmd_addr_dec (
    mmd_dec_if.dec d
);
    import mmd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // register address from bank and index
    function automatic logic [7:0] reg_addr(input logic [1:0] bank, input logic [2:0] idx);
        reg_addr = {3'h0, bank, idx};
    endfunction

    wire logic [7:0] reg_loc;
    wire logic [7:0] bit_byte;
    wire logic [7:0] sfr_bit_byte;
    wire logic [7:0] target;

    assign reg_loc      = reg_addr(d.bank, d.reg_idx);
    // bit area below 80h, sfr bits above
    assign bit_byte     = BIT_AREA_BASE + {4'h0, d.addr[6:3]};
    assign sfr_bit_byte = {d.addr[7:3], 3'h0};
    assign target = (d.mode == MMD_AM_REGISTER) ? reg_loc :
                    (d.mode == MMD_AM_INDIRECT) ? d.ind_ptr :
                    (d.mode == MMD_AM_BIT)      ? (d.addr[7] ? sfr_bit_byte : bit_byte) :
                    d.addr;
    assign d.ram_addr = target;
    assign d.bit_sel  = d.addr[2:0];
    assign d.is_ram   = (target < SFR_BASE);
    // indirect into the upper half reaches nothing
    assign d.is_sfr   = (target >= SFR_BASE) && (d.mode != MMD_AM_INDIRECT);
    assign d.illegal  = (target >= SFR_BASE) && (d.mode == MMD_AM_INDIRECT);
endmodule : mmd_addr_dec
`default_nettype wire

// ===== design/mmd_top.sv
`timescale 1ns/1ns
`default_nettype none
module mmd_top #(
    parameter int PROG_BYTES = mmd_pkg::PROG_MAX_BYTES
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // program counter control from core
    input  wire logic        pc_load_i,
    input  wire logic [15:0] pc_target_i,
    input  wire logic        pc_advance_i,
    input  wire logic        irq_take_i,
    input  wire logic [1:0]  irq_src_i,
    // program memory read port
    output logic [15:0]      prog_addr_o,
    output logic             prog_valid_o,
    output logic             prog_fetch_o,
    output logic             phase_end_o,
    // data access request from core
    input  wire logic        dreq_i,
    input  wire logic        dwrite_i,
    input  wire logic [1:0]  dmode_i,
    input  wire logic [7:0]  daddr_i,
    input  wire logic [2:0]  dreg_i,
    input  wire logic [7:0]  dwdata_i,
    input  wire logic        dbit_i,
    input  wire logic [1:0]  bank_sel_i,
    // data results
    output logic [7:0]       drdata_o,
    output logic             dbit_o,
    output logic             dack_o,
    output logic             derr_o,
    // special register port
    output logic             sfr_rd_o,
    output logic             sfr_wr_o,
    output logic [7:0]       sfr_addr_o,
    output logic [7:0]       sfr_wdata_o,
    input  wire logic [7:0]  sfr_rdata_i,
    output logic [7:0]       ptr_r0_o,
    output logic [7:0]       ptr_r1_o
);
    import mmd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // parameter check at elaboration
    // the validity compare is sixteen bits wide and the program space
    // never exceeds the largest size the address map allows
    if (PROG_BYTES < 1 || PROG_BYTES > PROG_MAX_BYTES) begin : g_bad_size
        $error("program size out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // shared helpers
    // ram index of register idx in bank: bank times eight plus index
    function automatic logic [6:0] bank_loc(input logic [1:0] bank, input logic [2:0] idx);
        bank_loc = {2'h0, bank, idx};
    endfunction

    // vector of an interrupt source, eight byte spacing from the base
    function automatic logic [15:0] vec_of(input logic [1:0] src);
        vec_of = VEC_BASE + {11'h0, src, 3'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // reset release synchroniser
    // assertion acts at once, release waits two edges so that no
    // register leaves reset on an edge too close to the pin change
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= 1'b1;
        end else begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire logic core_rst;
    assign core_rst = rst_sync_reg;

    ////////////////////////////////////////////////////////////////////
    // machine cycle phase counter, four clocks per machine cycle
    mmd_phase_e phase_reg;
    mmd_phase_e phase_next;
    // gray order keeps one state bit changing per clock
    always_comb begin
        case (phase_reg)
            MMD_PH0: phase_next = MMD_PH1;
            MMD_PH1: phase_next = MMD_PH2;
            MMD_PH2: phase_next = MMD_PH3;
            MMD_PH3: phase_next = MMD_PH0;
            default: phase_next = MMD_PH0;
        endcase
    end
    always_ff @(posedge mclk_i or posedge core_rst) begin
        if (core_rst) phase_reg <= MMD_PH0;
        else          phase_reg <= phase_next;
    end
    // phase 3 closes the cycle, phase 0 opens the fetch
    wire logic cyc_end;
    wire logic cyc_start;
    assign cyc_end      = (phase_reg == MMD_PH3);
    assign cyc_start    = (phase_reg == MMD_PH0);
    assign phase_end_o  = cyc_end;
    assign prog_fetch_o = cyc_start;

    ////////////////////////////////////////////////////////////////////
    // program counter, updated at end of each machine cycle
    // an interrupt outranks a load, a load outranks a step
    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    wire logic [15:0] vec_addr;
    wire logic [15:0] pc_inc;
    assign vec_addr = vec_of(irq_src_i);
    assign pc_inc   = pc_reg + 16'h0001;
    always_comb begin
        pc_next = pc_reg;
        if (cyc_end) begin
            if (irq_take_i)        pc_next = vec_addr;
            else if (pc_load_i)    pc_next = pc_target_i;
            else if (pc_advance_i) pc_next = pc_inc;
        end
    end
    always_ff @(posedge mclk_i or posedge core_rst) begin
        if (core_rst) pc_reg <= PC_RESET;
        else          pc_reg <= pc_next;
    end

    ////////////////////////////////////////////////////////////////////
    // program memory read port
    // read only: an address goes out, no write strobe or data exists;
    // all sixteen address bits leave even with less memory fitted
    assign prog_addr_o  = pc_reg;
    assign prog_valid_o = (pc_reg < 16'(PROG_BYTES));

    ////////////////////////////////////////////////////////////////////
    // internal data ram, 128 bytes, not cleared by reset
    logic [7:0] ram [0:127];

    // pointer registers of the active bank
    wire logic [6:0] r0_loc;
    wire logic [6:0] r1_loc;
    wire logic [6:0] ptr_loc;
    assign r0_loc  = bank_loc(bank_sel_i, 3'h0);
    assign r1_loc  = bank_loc(bank_sel_i, 3'h1);
    assign ptr_loc = dreg_i[0] ? r1_loc : r0_loc;

    ////////////////////////////////////////////////////////////////////
    // address decode
    mmd_dec_if dif ();
    assign dif.addr    = daddr_i;
    assign dif.mode    = dmode_i;
    assign dif.reg_idx = dreg_i;
    assign dif.bank    = bank_sel_i;
    assign dif.ind_ptr = ram[ptr_loc];
    mmd_addr_dec u_dec (
        .d (dif)
    );

    ////////////////////////////////////////////////////////////////////
    // request qualifiers, all taken on the edge that ends phase 3
    wire logic take;
    wire logic rd_take;
    wire logic wr_take;
    assign take    = dreq_i && cyc_end;
    assign rd_take = take && !dwrite_i && !dif.illegal;
    assign wr_take = take && dwrite_i && !dif.illegal;

    ////////////////////////////////////////////////////////////////////
    // byte and bit write path
    // a bit write is read-modify-write of the addressed byte, so the
    // other seven bits come back unchanged from ram or special space
    wire logic [6:0] ra;
    wire logic       bit_mode;
    wire logic [7:0] cur;
    wire logic [7:0] bit_mask;
    wire logic [7:0] bit_set;
    wire logic [7:0] bit_clr;
    wire logic [7:0] wr_byte;
    wire logic       ram_we;
    assign ra       = dif.ram_addr[6:0];
    assign bit_mode = (dmode_i == MMD_AM_BIT);
    assign cur      = dif.is_ram ? ram[ra] : sfr_rdata_i;
    assign bit_mask = 8'h01 << dif.bit_sel;
    assign bit_set  = cur | bit_mask;
    assign bit_clr  = cur & ~bit_mask;
    assign wr_byte  = bit_mode ? (dbit_i ? bit_set : bit_clr) : dwdata_i;
    assign ram_we   = wr_take && dif.is_ram;
    // ram write lands on the closing edge of the machine cycle
    always_ff @(posedge mclk_i) begin
        if (ram_we) ram[ra] <= wr_byte;
    end

    ////////////////////////////////////////////////////////////////////
    // special register port, direct and bit modes only
    // an indirect pointer into the upper half raises an error instead
    // of a strobe, so no special register is ever touched by it
    assign sfr_rd_o    = rd_take && dif.is_sfr;
    assign sfr_wr_o    = wr_take && dif.is_sfr;
    assign sfr_addr_o  = dif.ram_addr;
    assign sfr_wdata_o = wr_byte;
    assign dack_o      = take && !dif.illegal;
    assign derr_o      = take && dif.illegal;

    ////////////////////////////////////////////////////////////////////
    // read data captured at end of machine cycle, held until next read
    logic [7:0] rd_reg;
    logic       rbit_reg;
    always_ff @(posedge mclk_i or posedge core_rst) begin
        if (core_rst) begin
            rd_reg   <= 8'h00;
            rbit_reg <= 1'b0;
        end else if (rd_take) begin
            rd_reg   <= cur;
            rbit_reg <= cur[dif.bit_sel];
        end
    end
    assign drdata_o = rd_reg;
    assign dbit_o   = rbit_reg;

    // pointer registers of the active bank shown to the core
    assign ptr_r0_o = ram[r0_loc];
    assign ptr_r1_o = ram[r1_loc];
endmodule : mmd_top
`default_nettype wire

// ===== verif/mmd_sfr_model.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural special register space answering the decoder
module mmd_sfr_model (
    // clock and strobes from the decoder
    input  wire logic       mclk_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    // read data back to the decoder
    output logic [7:0]      rdata_o
);
    logic [7:0] mem_reg [256];
    // known start values so a stray read is visible
    initial foreach (mem_reg[i]) mem_reg[i] = 8'h55;
    assign rdata_o = mem_reg[addr_i];
    // write lands at the edge that ends phase 3
    always @(posedge mclk_i) if (wr_i) mem_reg[addr_i] <= wdata_i;
endmodule // mmd_sfr_model
`default_nettype wire

// ===== verif/mmd_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// watches the decoder top ports for address map rules
module mmd_chk
    import mmd_pkg::*;
#(
    parameter int PROG_BYTES = 4096
) (
    // clock, reset and program side
    input wire logic        mclk_i, rst_i, pc_load_i, pc_advance_i, irq_take_i,
    input wire logic [1:0]  irq_src_i,
    input wire logic [15:0] prog_addr_o,
    input wire logic        prog_valid_o, phase_end_o,
    // data side
    input wire logic        dreq_i, dwrite_i, dack_o, derr_o, sfr_rd_o, sfr_wr_o,
    input wire logic [1:0]  dmode_i,
    input wire logic [2:0]  dreg_i,
    input wire logic [7:0]  daddr_i, sfr_addr_o, ptr_r0_o, ptr_r1_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // request taken this phase and indirect pointer in use
    wire       take_w = phase_end_o && dreq_i;
    wire [7:0] ind_w  = dreg_i[0] ? ptr_r1_o : ptr_r0_o;
    ////////////////////////////////////////////////////////////
    phase_len_a: assert property (phase_end_o |=> !phase_end_o [*3] ##1 phase_end_o)
        else $error("machine cycle length wrong");
    rst_pc_a: assert property ($fell(rst_i) |-> prog_addr_o == PC_RESET)
        else $error("pc not zero after reset");
    take_irq_a: assert property (phase_end_o && irq_take_i |=>
        prog_addr_o == VEC_BASE + {11'h0, $past(irq_src_i), 3'h0}) else $error("wrong vector");
    pc_step_a: assert property (phase_end_o && pc_advance_i && !irq_take_i && !pc_load_i |=>
        prog_addr_o == $past(prog_addr_o) + 16'h1) else $error("pc step wrong");
    prog_valid_a: assert property (prog_valid_o == (prog_addr_o < PROG_BYTES))
        else $error("program range flag wrong");
    ind_err_a: assert property (take_w && dmode_i == MMD_AM_INDIRECT && ind_w[7] |->
        derr_o && !sfr_rd_o && !sfr_wr_o) else $error("indirect reached special space");
    sfr_dir_a: assert property (take_w && dmode_i == MMD_AM_DIRECT && daddr_i[7] |->
        sfr_addr_o == daddr_i && sfr_wr_o == dwrite_i && sfr_rd_o == !dwrite_i) else $error("direct sfr");
    ram_dir_a: assert property (take_w && dmode_i == MMD_AM_DIRECT && !daddr_i[7] |->
        dack_o && !sfr_rd_o && !sfr_wr_o) else $error("direct ram");
    sfr_bit_a: assert property (take_w && dmode_i == MMD_AM_BIT && daddr_i[7] |->
        sfr_addr_o == {daddr_i[7:3], 3'h0}) else $error("sfr bit address");
    strobe_ph_a: assert property (!phase_end_o |-> !dack_o && !derr_o && !sfr_rd_o && !sfr_wr_o)
        else $error("strobe outside phase 3");
    // main scenarios reached
    cov_irq: cover property (phase_end_o && irq_take_i);
    cov_err: cover property (derr_o);
    cov_sbit: cover property (take_w && dmode_i == MMD_AM_BIT && daddr_i[7]);
endmodule // mmd_chk
bind mmd_top mmd_chk #(.PROG_BYTES(PROG_BYTES)) i_chk (.*);
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import mmd_pkg::*;
    logic        mclk_i = 0, rst_i = 1, pc_load_i = 0, pc_advance_i = 0, irq_take_i = 0;
    logic        dreq_i = 0, dwrite_i = 0, dbit_i = 0, dk, de, sr, sw;
    logic        prog_valid_o, prog_fetch_o, phase_end_o, dbit_o, dack_o, derr_o, sfr_rd_o, sfr_wr_o;
    logic [1:0]  irq_src_i = 0, dmode_i = 0, bank_sel_i = 0;
    logic [2:0]  dreg_i = 0;
    logic [7:0]  daddr_i = 0, dwdata_i = 0, drdata_o, sfr_addr_o, sfr_wdata_o, sfr_rdata_i, ptr_r0_o, ptr_r1_o;
    logic [15:0] pc_target_i = 0, prog_addr_o;
    int          miscompares = 0, comparisons = 0, cycles = 0;
    mmd_top #(.PROG_BYTES(4096)) i_dut (.*);
    mmd_sfr_model i_sfr (.mclk_i(mclk_i), .wr_i(sfr_wr_o), .addr_i(sfr_addr_o), .wdata_i(sfr_wdata_o),
        .rdata_o(sfr_rdata_i));
    ////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string s);
        comparisons++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, s);
        end
    endtask
    // one machine cycle, strobes sampled in phase 3
    task automatic mc();
        repeat (3) @(posedge mclk_i);
        #1 {dk, de, sr, sw} = {dack_o, derr_o, sfr_rd_o, sfr_wr_o};
        @(posedge mclk_i);
        #1;
    endtask
    task automatic acc(input logic w, input logic [1:0] m, input logic [7:0] a, input logic [7:0] d);
        {dreq_i, dwrite_i, dmode_i, daddr_i, dreg_i, dwdata_i, dbit_i} = {1'b1, w, m, a, a[2:0], d, d[0]};
        mc();
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_pc();
        chk(prog_addr_o === PC_RESET && prog_fetch_o === 1'b1, "reset pc");
        for (int s = 0; s < NUM_IRQ; s++) begin
            {irq_take_i, irq_src_i, pc_load_i, pc_advance_i, pc_target_i} = {1'b1, 2'(s), 2'b10, 16'h0800};
            mc();
            chk(prog_addr_o === VEC_BASE + 16'(s * 8), "vector");
        end
        {irq_take_i, pc_load_i, pc_advance_i} = 3'b001;
        mc();
        chk(prog_addr_o === 16'h001c, "step in vector slot");
        {pc_load_i, pc_advance_i, pc_target_i} = {2'b10, 16'h1000};
        mc();
        chk(prog_addr_o === 16'h1000 && prog_valid_o === 1'b0, "beyond program size");
        {pc_load_i, pc_advance_i} = 2'b00;
    endtask
    task automatic t_data();
        acc(1, MMD_AM_REGISTER, 8'h00, 8'h11);
        acc(1, MMD_AM_DIRECT, 8'h7f, 8'h3c);
        acc(0, MMD_AM_DIRECT, 8'h7f, 8'h00);
        chk(drdata_o === 8'h3c && {dk, de, sr, sw} === 4'h8, "ram top byte");
        bank_sel_i = 2'h2;
        acc(1, MMD_AM_REGISTER, 8'h00, 8'h7f);
        acc(1, MMD_AM_REGISTER, 8'h01, 8'h85);
        chk(ptr_r0_o === 8'h7f && ptr_r1_o === 8'h85, "bank pointers");
        acc(0, MMD_AM_DIRECT, 8'h10, 8'h00);
        chk(drdata_o === 8'h7f, "bank address");
        acc(0, MMD_AM_INDIRECT, 8'h00, 8'h00);
        chk(drdata_o === 8'h3c, "indirect read");
        acc(0, MMD_AM_INDIRECT, 8'h01, 8'h00);
        chk({de, sr, sw} === 3'h4, "indirect to special space");
        bank_sel_i = 2'h0;
        acc(0, MMD_AM_REGISTER, 8'h00, 8'h00);
        chk(ptr_r0_o === 8'h11 && drdata_o === 8'h11, "bank switch");
    endtask
    task automatic t_bits();
        acc(1, MMD_AM_DIRECT, 8'h21, 8'h00);
        acc(1, MMD_AM_BIT, 8'h0b, 8'h01);
        acc(0, MMD_AM_DIRECT, 8'h21, 8'h00);
        chk(drdata_o === 8'h08, "bit 0b");
        acc(1, MMD_AM_DIRECT, 8'h2f, 8'h00);
        acc(1, MMD_AM_BIT, 8'h7f, 8'h01);
        acc(0, MMD_AM_BIT, 8'h7f, 8'h00);
        chk(dbit_o === 1'b1, "bit 7f");
        acc(0, MMD_AM_DIRECT, 8'h2f, 8'h00);
        chk(drdata_o === 8'h80, "byte 2f");
        acc(1, MMD_AM_DIRECT, 8'h90, 8'h00);
        acc(1, MMD_AM_BIT, 8'h93, 8'h01);
        acc(0, MMD_AM_DIRECT, 8'h90, 8'h00);
        chk(drdata_o === 8'h08 && sr === 1'b1, "special bit");
    endtask
    ////////////////////////////////////////////////////////////
    // clock, timeout and main sequence
    initial forever #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        // the design releases its own reset two edges later
        repeat (2) @(posedge mclk_i);
        #1;
        t_pc();
        t_data();
        t_bits();
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
